//--- common/flash_front_consts.svh
// Purpose: Timing counts, opcodes and field values for the serial front end
// Assumes: Core clock period in whole nanoseconds
// Notes:   Definitions only
`ifndef FLASH_FRONT_CONSTS_SVH
`define FLASH_FRONT_CONSTS_SVH

`define CLK_PERIOD_NS          5
`define SW_RESET_TIME_NS       10000
`define HARD_CLEAR_PULSE_MIN_NS 1000
`define SW_RESET_CYCLES        ((`SW_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HARD_CLEAR_MIN_CYCLES  ((`HARD_CLEAR_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define OP_ENTER_FOUR_LINE     8'h38
`define OP_EXIT_FOUR_LINE      8'hff
`define OP_RESET_ENABLE        8'h66
`define OP_RESET               8'h99
`define OP_DUAL_OUT_READ       8'h3b
`define OP_DUAL_IO_READ        8'hbb
`define OP_QUAD_OUT_READ       8'h6b
`define OP_QUAD_IO_READ        8'heb

`define INSTR_BITS             8
`define OE_ONE_LINE            4'hd
`define OE_TWO_LINE            4'hc
`define OE_FOUR_LINE           4'h0
`define OE_NONE                4'hf

`endif

//--- common/flash_front_pkg.sv
// Purpose: State types of the serial front end
// Assumes: Nothing
// Notes:   One struct per clock/reset group
package flash_front_pkg;
  typedef enum logic [1:0] {LANE1, LANE2, LANE4} lane_t;
  typedef enum logic [2:0] {PH_INSTR, PH_ADDR, PH_DUMMY, PH_DRIVE, PH_IDLE} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [5:0]  cnt;
    logic [7:0]  shreg;
    lane_t       in_w;
    lane_t       out_w;
  } link_t;

  typedef struct packed {
    logic        four_line;
    logic        armed;
    logic        cmd_tog;
    logic        rst_tog;
    logic [7:0]  cmd_code;
  } mode_t;

  typedef struct packed {
    logic        held;
    logic [3:0]  dout;
    logic [7:0]  osh;
    logic [3:0]  left;
  } drive_t;

  typedef struct packed {
    logic [11:0] busy_cnt;
    logic [7:0]  low_cnt;
    logic        sw_busy;
    logic        hw_busy;
    logic        link_clear;
    logic        cmd_seen;
    logic        rst_seen;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic        abort;
    logic        four_line;
  } core_t;
endpackage

//--- rtl/bit_sync.sv
// Purpose: Two-stage synchroniser for quasi-static levels
// Assumes: Each bit is a level or a toggle
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in)
  begin
    meta_reg <= d_in;
    q_out    <= meta_reg;
  end
endmodule // bit_sync
`default_nettype wire

//--- rtl/flash_front.sv
// Purpose: Serial clock front end: modes, lanes, pause, resets
// Assumes: Serial clock stands still outside frames
// Notes:   Link logic on sclk_in, control on clk_in
// Behaviour
// RULE1: Only clock modes 0 and 3 supported
// RULE2: Sample on rising edge, drive on falling
// RULE3: Master parks clock low or high idle
// RULE4: Cycles count falling edge to falling edge
// RULE5: Opcodes 3Bh, BBh use two data lines; in four-line mode the code runs them on four
// RULE6: Opcodes 6Bh, EBh use four data lines
// RULE7: Quad instructions need quad enable set
// RULE8: 38h enters, FFh leaves four-line mode
// RULE9: Instruction takes eight clocks or two
// RULE10: Reset and power-up leave four-line mode
// RULE11: Four-line entry needs quad enable set
// RULE12: Pause only single/dual, chip select low
// RULE13: Pause starts at hold fall when clock low
// RULE14: Pause ends at hold rise when clock low
// RULE15: Paused: outputs released, inputs and clock ignored
// RULE16: Master keeps chip select low while paused
// RULE17: Software reset is 66h then 99h
// RULE18: About 10us reset, commands rejected
// RULE19: Select bit picks pause or reset pin
// RULE20: Low reset pin clears, blocks commands
// RULE21: Quad enable turns shared pin into data
// RULE22: Reset pin overrides every other input
// RULE23: Quad enable frees write-protect and shared pin
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_consts.svh"
module flash_front #(
  parameter int ADDR_BITS  = 24,
  parameter int DUMMY_CLKS = 8
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       data_line_0_in,
  input  wire logic       data_line_1_in,
  input  wire logic       data_line_2_in,
  input  wire logic       data_line_3_in,
  output logic            data_line_0_out,
  output logic            data_line_1_out,
  output logic            data_line_2_out,
  output logic            data_line_3_out,
  output logic            data_line_0_oe_n_out,
  output logic            data_line_1_oe_n_out,
  output logic            data_line_2_oe_n_out,
  output logic            data_line_3_oe_n_out,
  input  wire logic       quad_enable_bit_in,
  input  wire logic       shared_pin_function_select_in,
  input  wire logic [7:0] read_data_in,
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_code_out,
  output logic            busy_out,
  output logic            hw_reset_out,
  output logic            abort_out,
  output logic            four_line_command_mode_out
);
  import flash_front_pkg::*;

  if (DUMMY_CLKS < 1 || DUMMY_CLKS > 63 || ADDR_BITS < 8 || ADDR_BITS > 63
      || (ADDR_BITS % 4) != 0)
  begin : g_check
    $error("flash_front: unsupported ADDR_BITS or DUMMY_CLKS");
  end

  localparam logic [11:0] SW_CYC  = 12'(`SW_RESET_CYCLES);
  localparam logic [7:0]  MIN_CYC = 8'(`HARD_CLEAR_MIN_CYCLES);

  link_t      lk, ln;
  mode_t      md, mn;
  drive_t     dv, dn;
  core_t      cr, cn;
  logic [3:0] oe_n_reg, oe_n_next;
  logic [3:0] din;
  logic [9:0] sck_sync;
  logic [3:0] core_sync;
  logic       qe_s, sel_s, hold_en, link_rst, pause_now, hw_req;
  logic [7:0] rd_s;

  assign din       = {data_line_3_in, data_line_2_in, data_line_1_in, data_line_0_in};
  assign link_rst  = cs_n_in | cr.link_clear;
  assign qe_s      = sck_sync[9];
  assign sel_s     = sck_sync[8];
  assign rd_s      = sck_sync[7:0];
  // Pause only while shared pin is a pause pin in single/dual use
  assign hold_en   = ~qe_s & ~sel_s & ~md.four_line;  // [RULE12] [RULE19] [RULE21]
  // Pause taking effect while the clock is already low
  assign pause_now = hold_en & ~data_line_3_in & ~sclk_in;  // [RULE13]

  bit_sync #(.WIDTH(10)) u_sck_sync (
    .clk_in (sclk_in),
    .d_in   ({quad_enable_bit_in, shared_pin_function_select_in, read_data_in}),
    .q_out  (sck_sync)
  );

  bit_sync #(.WIDTH(4)) u_core_sync (
    .clk_in (clk_in),
    .d_in   ({data_line_3_in, md.cmd_tog, md.rst_tog, md.four_line}),
    .q_out  (core_sync)
  );

  function automatic logic [5:0] clocks_for(input lane_t w, input int bits);
    logic [5:0] c;
    c = 6'(bits);
    case (w)
      LANE1:   return c;
      LANE2:   return c >> 1;
      default: return c >> 2;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s, input lane_t w,
                                          input logic [3:0] d);
    case (w)
      LANE1:   return {s[6:0], d[0]};
      LANE2:   return {s[5:0], d[1:0]};
      default: return {s[3:0], d};
    endcase
  endfunction

  // Rising-edge capture and instruction decode
  always_comb
  begin
    lane_t      iw;
    logic [7:0] sh;
    iw = md.four_line ? LANE4 : LANE1;
    sh = 8'h00;
    ln = lk;
    mn = md;
    if (!(hold_en && !data_line_3_in))  // [RULE15]
    begin
      sh       = shift_in(lk.shreg, (lk.phase == PH_INSTR) ? iw : lk.in_w, din);  // [RULE2]
      ln.shreg = sh;
      ln.cnt   = lk.cnt + 6'h01;
      case (lk.phase)
        PH_INSTR:
        begin
          if (lk.cnt == clocks_for(iw, `INSTR_BITS) - 6'h01)  // [RULE9]
          begin
            ln.cnt      = 6'h00;
            ln.phase    = PH_IDLE;
            mn.cmd_code = sh;
            mn.cmd_tog  = ~md.cmd_tog;
            mn.armed    = 1'b0;
            if (sh == `OP_ENTER_FOUR_LINE && qe_s)
              mn.four_line = 1'b1;  // [RULE8] [RULE11]
            else if (sh == `OP_EXIT_FOUR_LINE)
              mn.four_line = 1'b0;  // [RULE8]
            else if (sh == `OP_RESET_ENABLE)
              mn.armed = 1'b1;  // [RULE17]
            else if (sh == `OP_RESET && md.armed)
              mn.rst_tog = ~md.rst_tog;  // [RULE17]
            if (md.four_line && qe_s && (sh == `OP_DUAL_OUT_READ || sh == `OP_DUAL_IO_READ
                || sh == `OP_QUAD_OUT_READ || sh == `OP_QUAD_IO_READ))
            begin
              ln.phase = PH_ADDR;
              ln.in_w  = LANE4;
              ln.out_w = LANE4;
            end
            else if (!md.four_line && sh == `OP_DUAL_OUT_READ)
            begin
              ln.phase = PH_ADDR;  // [RULE5]
              ln.in_w  = LANE1;
              ln.out_w = LANE2;
            end
            else if (!md.four_line && sh == `OP_DUAL_IO_READ)
            begin
              ln.phase = PH_ADDR;  // [RULE5]
              ln.in_w  = LANE2;
              ln.out_w = LANE2;
            end
            else if (!md.four_line && qe_s && sh == `OP_QUAD_OUT_READ)
            begin
              ln.phase = PH_ADDR;  // [RULE6] [RULE7] [RULE23]
              ln.in_w  = LANE1;
              ln.out_w = LANE4;
            end
            else if (!md.four_line && qe_s && sh == `OP_QUAD_IO_READ)
            begin
              ln.phase = PH_ADDR;  // [RULE6] [RULE7] [RULE23]
              ln.in_w  = LANE4;
              ln.out_w = LANE4;
            end
          end
        end
        PH_ADDR:
        begin
          if (lk.cnt == clocks_for(lk.in_w, ADDR_BITS) - 6'h01)
          begin
            ln.cnt   = 6'h00;
            ln.phase = PH_DUMMY;
          end
        end
        PH_DUMMY:
        begin
          if (lk.cnt == 6'(DUMMY_CLKS - 1))
          begin
            ln.cnt   = 6'h00;
            ln.phase = PH_DRIVE;
          end
        end
        default:
          ln.cnt = lk.cnt;
      endcase
    end
  end

  // Frame state restarts whenever chip select rises
  always_ff @(posedge sclk_in or posedge link_rst)
  begin
    if (link_rst)
      lk <= '{phase: PH_INSTR, cnt: 6'h00, shreg: 8'h00, in_w: LANE1, out_w: LANE1};
    else
      lk <= ln;
  end

  // Mode survives frames; cleared by power-up and resets
  always_ff @(posedge sclk_in or posedge cr.link_clear)
  begin
    if (cr.link_clear)
      md <= '{four_line: 1'b0, armed: 1'b0, cmd_tog: 1'b0, rst_tog: 1'b0,
              cmd_code: 8'h00};  // [RULE10]
    else
      md <= mn;
  end

  // Falling-edge drive and pause tracking
  always_comb
  begin
    logic [7:0] w;
    w         = 8'h00;
    dn        = dv;
    oe_n_next = `OE_NONE;
    dn.held   = hold_en & ~data_line_3_in;  // [RULE13] [RULE14]
    if (!dn.held && lk.phase == PH_DRIVE)  // [RULE2]
    begin
      w = (dv.left == 4'h0) ? rd_s : dv.osh;
      case (lk.out_w)
        LANE1:
        begin
          dn.dout   = {2'b00, w[7], 1'b0};
          dn.osh    = {w[6:0], 1'b0};
          dn.left   = ((dv.left == 4'h0) ? 4'h8 : dv.left) - 4'h1;
          oe_n_next = `OE_ONE_LINE;
        end
        LANE2:
        begin
          dn.dout   = {2'b00, w[7:6]};
          dn.osh    = {w[5:0], 2'b00};
          dn.left   = ((dv.left == 4'h0) ? 4'h8 : dv.left) - 4'h2;
          oe_n_next = `OE_TWO_LINE;  // [RULE5]
        end
        default:
        begin
          dn.dout   = w[7:4];
          dn.osh    = {w[3:0], 4'h0};
          dn.left   = ((dv.left == 4'h0) ? 4'h8 : dv.left) - 4'h4;
          oe_n_next = `OE_FOUR_LINE;  // [RULE6]
        end
      endcase
    end
  end

  always_ff @(negedge sclk_in or posedge link_rst)
  begin
    if (link_rst)
      dv <= '{held: 1'b0, dout: 4'h0, osh: 8'h00, left: 4'h0};
    else
      dv <= dn;
  end

  // Outputs released at once when a pause starts with clock low
  always_ff @(negedge sclk_in or posedge link_rst or posedge pause_now)
  begin
    if (link_rst || pause_now)
      oe_n_reg <= `OE_NONE;  // [RULE15]
    else
      oe_n_reg <= oe_n_next;
  end

  assign data_line_0_out      = dv.dout[0];
  assign data_line_1_out      = dv.dout[1];
  assign data_line_2_out      = dv.dout[2];
  assign data_line_3_out      = dv.dout[3];
  assign data_line_0_oe_n_out = oe_n_reg[0];
  assign data_line_1_oe_n_out = oe_n_reg[1];
  assign data_line_2_oe_n_out = oe_n_reg[2];
  assign data_line_3_oe_n_out = oe_n_reg[3];

  // Core: resets, command events, status
  assign hw_req = shared_pin_function_select_in & ~quad_enable_bit_in
                  & ~core_sync[3];  // [RULE19] [RULE21]

  always_comb
  begin
    cn           = cr;
    cn.cmd_valid = 1'b0;
    cn.abort     = 1'b0;
    cn.four_line = core_sync[0];
    if (hw_req)
    begin
      cn.abort   = ~cr.hw_busy;  // [RULE20] [RULE22]
      cn.hw_busy = 1'b1;
      cn.low_cnt = (cr.low_cnt == MIN_CYC) ? cr.low_cnt : cr.low_cnt + 8'h01;
    end
    else if (cr.hw_busy)
    begin
      if (cr.low_cnt >= MIN_CYC)
      begin
        cn.hw_busy = 1'b0;
        cn.low_cnt = 8'h00;
      end
      else
        cn.low_cnt = cr.low_cnt + 8'h01;
    end
    if (cr.sw_busy)
    begin
      cn.busy_cnt = cr.busy_cnt - 12'h001;
      if (cr.busy_cnt == 12'h001)
        cn.sw_busy = 1'b0;  // [RULE18]
    end
    if (cr.link_clear || hw_req)
    begin
      cn.cmd_seen = core_sync[2];
      cn.rst_seen = core_sync[1];
    end
    else
    begin
      if (core_sync[2] != cr.cmd_seen)
      begin
        cn.cmd_seen  = core_sync[2];
        cn.cmd_valid = 1'b1;
        cn.cmd_code  = md.cmd_code;
      end
      if (core_sync[1] != cr.rst_seen)
      begin
        cn.rst_seen = core_sync[1];
        cn.sw_busy  = 1'b1;  // [RULE17] [RULE18]
        cn.busy_cnt = SW_CYC;
        cn.abort    = 1'b1;
      end
    end
    cn.link_clear = cn.sw_busy | cn.hw_busy;  // [RULE22]
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cr <= '{busy_cnt: SW_CYC, low_cnt: 8'h00, sw_busy: 1'b1, hw_busy: 1'b0,
              link_clear: 1'b1, cmd_seen: 1'b0, rst_seen: 1'b0, cmd_valid: 1'b0,
              cmd_code: 8'h00, abort: 1'b0, four_line: 1'b0};
    else
      cr <= cn;
  end

  assign cmd_valid_out              = cr.cmd_valid;
  assign cmd_code_out               = cr.cmd_code;
  assign busy_out                   = cr.link_clear;
  assign hw_reset_out               = cr.hw_busy;
  assign abort_out                  = cr.abort;
  assign four_line_command_mode_out = cr.four_line;

  property p_sw_reset_len;
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(cr.sw_busy) |-> (cr.busy_cnt == SW_CYC) ##1 busy_out [*8];
  endproperty
  a_sw_reset_len: assert property (p_sw_reset_len)  // [RULE18]
    else $error("soft reset period too short");

  property p_hw_block;
    @(posedge clk_in) disable iff (!rst_n_in)
    hw_req |=> (hw_reset_out && busy_out && !cmd_valid_out);
  endproperty
  a_hw_block: assert property (p_hw_block)  // [RULE20]
    else $error("hardware reset did not block commands");

  property p_hw_override;
    @(posedge clk_in) disable iff (!rst_n_in)
    hw_reset_out |-> cr.link_clear;
  endproperty
  a_hw_override: assert property (p_hw_override)  // [RULE22]
    else $error("hardware reset did not clear link");

  property p_reset_mode;
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(cr.sw_busy) |-> ##4 !four_line_command_mode_out;
  endproperty
  a_reset_mode: assert property (p_reset_mode)  // [RULE10]
    else $error("four-line mode survived reset");

  property p_instr_len;
    @(posedge sclk_in) disable iff (link_rst)
    (lk.phase == PH_INSTR && ln.phase != PH_INSTR) |-> lk.cnt == (md.four_line ? 6'h01 : 6'h07);
  endproperty
  a_instr_len: assert property (p_instr_len)  // [RULE9]
    else $error("instruction length wrong");

  property p_enter_qe;
    @(posedge sclk_in) disable iff (cr.link_clear)
    $rose(md.four_line) |-> qe_s;
  endproperty
  a_enter_qe: assert property (p_enter_qe)  // [RULE11]
    else $error("four-line mode entered without quad enable");

  property p_pause_release;
    @(negedge sclk_in) disable iff (link_rst)
    dv.held |-> oe_n_reg == `OE_NONE;
  endproperty
  a_pause_release: assert property (p_pause_release)  // [RULE15]
    else $error("output driven during pause");

  property p_reset_pair;
    @(posedge sclk_in) disable iff (cr.link_clear)
    $changed(md.rst_tog) |-> $past(md.armed);
  endproperty
  a_reset_pair: assert property (p_reset_pair)  // [RULE17]
    else $error("reset without enable");

  property p_quad_qe;
    @(posedge sclk_in) disable iff (link_rst)
    (lk.phase == PH_DRIVE && lk.out_w == LANE4) |-> qe_s;
  endproperty
  a_quad_qe: assert property (p_quad_qe)  // [RULE7]
    else $error("quad transfer without quad enable");

  property p_pause_freeze;
    @(posedge sclk_in) disable iff (link_rst)
    (hold_en && !data_line_3_in) |=> $stable(lk);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze)  // [RULE15]
    else $error("state moved during pause");

  c_sw_reset: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(cr.sw_busy));
  c_hw_reset: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(hw_reset_out));
  c_four: cover property (@(posedge clk_in) disable iff (!rst_n_in)
                          $rose(four_line_command_mode_out));
  c_quad: cover property (@(negedge sclk_in) disable iff (link_rst)
                          oe_n_reg == `OE_FOUR_LINE);
endmodule // flash_front
`default_nettype wire

//--- testbench/spi_master_model.sv
// Purpose: Bus master model for the serial link, clock mode 0 or 3
// Assumes: Board pull-ups on all four data lines
// Notes:   Clock pulses only inside frames, idle level set while chip select is high; bench calls the tasks
`timescale 1ns/1ps
`default_nettype none
module spi_master_model #(
  parameter int DUMMY_CLKS = 8
) (
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic [3:0]      drv_out,
  output logic [3:0]      drv_en_out,
  input  wire logic [3:0] line_in,
  input  wire logic [3:0] dev_oe_n_in
);
  logic [3:0] cap;
  logic [3:0] hold_oe_n;
  logic [7:0] rx [2];
  logic       mode3;
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    drv_out = 4'hf;
    drv_en_out = 4'hc;
    mode3 = 1'b0;
  end
  // Pause with clock low, one ignored clock, release with clock low
  task automatic pause_seq();
    drv_out[3] = 1'b0;
    #8;
    hold_oe_n = dev_oe_n_in;
    sclk_out = 1'b1;
    #8;
    sclk_out = 1'b0;
    #8;
    hold_oe_n = hold_oe_n & dev_oe_n_in;
    drv_out[3] = 1'b1;
  endtask
  task automatic cyc(input logic [3:0] v, input logic [3:0] en, input bit p);
    sclk_out = 1'b0;
    drv_out = v;
    drv_en_out = en;
    #8;
    if (p) pause_seq();
    #8;
    sclk_out = 1'b1;
    cap = line_in;
    #16;
  endtask
  task automatic send(input logic [7:0] b, input int w);
    for (int i = 0; i < 8 / w; i++)
    begin
      if (w == 1) cyc({3'b110, b[7]}, 4'b1101, 1'b0);
      else if (w == 2) cyc({2'b11, b[7:6]}, 4'b1111, 1'b0);
      else cyc(b[7:4], 4'b1111, 1'b0);
      b = b << w;
    end
  endtask
  task automatic frame(input bit m3, input bit four, input logic [7:0] op,
                       input int aw, input int ow, input int pb);
    logic [7:0] b;
    mode3 = m3;
    sclk_out = m3;
    #16;
    cs_n_out = 1'b0;
    send(op, four ? 4 : 1);
    if (ow > 0)
    begin
      repeat (3) send(8'h00, aw);
      repeat (DUMMY_CLKS) cyc(4'hf, ow == 4 ? 4'h0 : 4'hc, 1'b0);
      for (int k = 0; k < 2; k++)
      begin
        b = 8'h00;
        for (int i = 0; i < 8 / ow; i++)
        begin
          cyc(4'hf, ow == 4 ? 4'h0 : 4'hc, k == pb && i == 0);
          b = (b << ow) | {4'h0, cap & (ow == 4 ? 4'hf : 4'h3)};
        end
        rx[k] = b;
      end
    end
    if (!mode3) sclk_out = 1'b0;
    #16;
    cs_n_out = 1'b1;
    drv_out = 4'hf;
    drv_en_out = 4'hc;
    #64;
  endtask
  task automatic hold_line3(input int ns);
    drv_out[3] = 1'b0;
    #ns;
    drv_out[3] = 1'b1;
  endtask
endmodule // spi_master_model
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench of the serial front end
// Assumes: Default address and dummy lengths of the design
// Notes:   Expected opcodes kept in a queue, popped at each decode
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 1'b0, rst_n_in = 1'b0, qe = 1'b0, sel = 1'b0, track = 1'b1;
  logic [7:0] rd = 8'h00, code;
  logic [16:0] seed = 17'h16dbf;
  wire logic sclk, cs_n, cmd_valid, busy, hw_rst, abort, four;
  wire logic [3:0] drv, drv_en, dout, oe_n;
  logic [3:0] lvl;
  logic [7:0] exp_q[$];
  int failures = 0, n_compared = 0, n_abort = 0, a0;
  always #2.5 clk_in = ~clk_in;
  always_comb
    for (int i = 0; i < 4; i++)
      lvl[i] = !oe_n[i] ? dout[i] : (drv_en[i] ? drv[i] : 1'b1);
  flash_front flash_front_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .data_line_0_in(lvl[0]), .data_line_1_in(lvl[1]),
    .data_line_2_in(lvl[2]), .data_line_3_in(lvl[3]), .data_line_0_out(dout[0]),
    .data_line_1_out(dout[1]), .data_line_2_out(dout[2]), .data_line_3_out(dout[3]),
    .data_line_0_oe_n_out(oe_n[0]), .data_line_1_oe_n_out(oe_n[1]),
    .data_line_2_oe_n_out(oe_n[2]), .data_line_3_oe_n_out(oe_n[3]),
    .quad_enable_bit_in(qe), .shared_pin_function_select_in(sel), .read_data_in(rd),
    .cmd_valid_out(cmd_valid), .cmd_code_out(code), .busy_out(busy),
    .hw_reset_out(hw_rst), .abort_out(abort), .four_line_command_mode_out(four));
  spi_master_model spi_master_model_inst (.sclk_out(sclk), .cs_n_out(cs_n),
    .drv_out(drv), .drv_en_out(drv_en), .line_in(lvl), .dev_oe_n_in(oe_n));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic complete_run();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic setc(input logic q, input logic s);
    @(negedge clk_in);
    qe = q;
    sel = s;
    seed = lfsr(seed);
    rd = seed[7:0];
    cycles(4);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000)
    begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 3000) failures++;
    cycles(4);
  endtask
  task automatic instr(input bit m3, input bit fl, input logic [7:0] op, input bit ex);
    if (ex) exp_q.push_back(op);
    spi_master_model_inst.frame(m3, fl, op, 0, 0, -1);
    cycles(10);
  endtask
  task automatic rd_chk(input bit m3, input bit fl, input logic [7:0] op,
                        input int aw, input int ow, input int pb);
    exp_q.push_back(op);
    spi_master_model_inst.frame(m3, fl, op, aw, ow, pb);
    chk_byte("read byte 0", rd, spi_master_model_inst.rx[0]);
    chk_byte("read byte 1", rd, spi_master_model_inst.rx[1]);
  endtask
  always @(posedge clk_in)
  begin
    if (abort === 1'b1) n_abort++;
    if (cmd_valid === 1'b1 && track)
    begin
      if (exp_q.size() == 0) chk_bit("cmd_valid_out", 1'b0, 1'b1);
      else chk_byte("cmd_code_out", exp_q.pop_front(), code);
    end
  end
  // Three reset periods plus some twenty frames stay far below this
  initial
  begin
    #400000;
    failures++;
    complete_run();
  end
  initial
  begin
    logic [7:0] ops [4] = '{8'h3b, 8'hbb, 8'h6b, 8'heb};
    int aws [4] = '{1, 2, 1, 4};
    int ows [4] = '{2, 2, 4, 4};
    cycles(12);
    rst_n_in = 1'b1;
    cycles(2);
    chk_bit("busy_out", 1'b1, busy);
    chk_bit("four_line_command_mode_out", 1'b0, four);
    wait_idle();
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      instr(i[0], 1'b0, {4'h0, seed[3:0]}, 1'b1);
    end
    $display("test decode done");
    setc(1'b0, 1'b0);
    instr(1'b0, 1'b0, 8'h38, 1'b1);
    chk_bit("four_line_command_mode_out", 1'b0, four);
    rd_chk(1'b0, 1'b0, 8'h3b, 1, 2, 1);
    chk_byte("paused oe_n", 8'h0f, {4'h0, spi_master_model_inst.hold_oe_n});
    track = 1'b0;
    spi_master_model_inst.frame(1'b0, 1'b0, 8'h6b, 1, 4, -1);
    chk_byte("refused quad read", 8'hff, spi_master_model_inst.rx[0]);
    cycles(10);
    track = 1'b1;
    $display("test pause done");
    for (int i = 0; i < 4; i++)
    begin
      setc(1'b1, 1'b0);
      rd_chk(i[0], 1'b0, ops[i], aws[i], ows[i], -1);
    end
    instr(1'b1, 1'b0, 8'h38, 1'b1);
    chk_bit("four_line_command_mode_out", 1'b1, four);
    setc(1'b1, 1'b0);
    rd_chk(1'b0, 1'b1, 8'heb, 4, 4, -1);
    instr(1'b0, 1'b1, 8'hff, 1'b1);
    chk_bit("four_line_command_mode_out", 1'b0, four);
    $display("test lanes done");
    instr(1'b0, 1'b0, 8'h38, 1'b1);
    a0 = n_abort;
    instr(1'b0, 1'b1, 8'h66, 1'b1);
    instr(1'b0, 1'b1, 8'h05, 1'b1);
    instr(1'b0, 1'b1, 8'h99, 1'b1);
    chk_bit("abort_out seen", 1'b0, n_abort != a0);
    instr(1'b1, 1'b1, 8'h66, 1'b1);
    instr(1'b1, 1'b1, 8'h99, 1'b1);
    chk_bit("abort_out seen", 1'b1, n_abort == a0 + 1);
    chk_bit("busy_out", 1'b1, busy);
    chk_bit("four_line_command_mode_out", 1'b0, four);
    instr(1'b0, 1'b0, 8'h05, 1'b0);
    wait_idle();
    $display("test soft reset done");
    setc(1'b0, 1'b1);
    a0 = n_abort;
    fork
      spi_master_model_inst.hold_line3(1250);
      begin
        cycles(100);
        chk_bit("hw_reset_out", 1'b1, hw_rst);
        chk_bit("busy_out", 1'b1, busy);
      end
    join
    chk_bit("abort_out seen", 1'b1, n_abort == a0 + 1);
    wait_idle();
    setc(1'b1, 1'b1);
    fork
      spi_master_model_inst.hold_line3(1250);
      begin
        cycles(100);
        chk_bit("hw_reset_out", 1'b0, hw_rst);
        chk_bit("busy_out", 1'b0, busy);
      end
    join
    instr(1'b0, 1'b0, 8'h05, 1'b1);
    chk_byte("pending decodes", 8'h00, 8'(exp_q.size()));
    $display("test hard reset done");
    complete_run();
  end
endmodule // tb
`default_nettype wire
